// File: cla_regs.svh
// How it works
// - Termination-current limit byte, 50uV steps up to 12.75mV, gates full detection.
// - Empty-voltage limit byte, 19.5mV steps, compared with mean cell voltage.
// - Empty-current limit byte, discharge magnitude in 200uV steps, up to 51.0mV.
// - Rated wear charge is sixteen bits in coulomb-count units of 6.25uVh.
// - Wear scale ratio byte weighs 2^-7 per step; 80h means unaged.
// - Wear scale ratio never drops below 40h, whatever lowers it.
// - Host reads and writes the ratio; it is saved and recalled automatically.
// - Discharge advances a wear counter; at 32 times rated charge ratio drops one.
// - A completed learn cycle resets the wear counter.
// - Full while learn-armed clears armed, sets full flag, relearns the ratio.
// - Full loads the count with scaled full value, after any ratio update.
// - Low voltage without learn lowers the count to empty value only if above.
// - Learn-armed loads the count with the empty model value unconditionally.
// - Full needs mean voltage above limit over two readings below termination current.
// - Both full-detect current readings must be positive and above 16 LSB.
// - Full detection sets the full-reached status flag.
// - Mean below empty limit with two strong discharge readings arms learning.
// - Low-voltage flag sets on the voltage crossing alone; clears when relative active remaining exceeds 5%.
// - Full-voltage limit byte, 19.5mV steps, compared with mean cell voltage.
// - Learn-armed clears on completion, discharge, zero count, count write, sleep.
// - Full-reached clears when relative active remaining falls below 90%.
`ifndef CLA_REGS_SVH
`define CLA_REGS_SVH

`define CLA_IDX_TERM_CUR   3'h0
`define CLA_IDX_EMPTY_VOLT 3'h1
`define CLA_IDX_EMPTY_CUR  3'h2
`define CLA_IDX_WEAR_HI    3'h3
`define CLA_IDX_WEAR_LO    3'h4
`define CLA_IDX_RATIO      3'h5
`define CLA_IDX_FULL_VOLT  3'h6
`define CLA_IDX_STATUS     3'h7

`define CLA_RST_BYTE       8'h00
`define CLA_RST_WEAR       16'h0000
`define CLA_RST_RATIO      8'h80
`define CLA_RATIO_FLOOR    8'h40

`define CLA_ST_FULL_BIT    7
`define CLA_ST_LOWV_BIT    6
`define CLA_ST_LEARN_BIT   4

`define CLA_VOLT_SHIFT     2
`define CLA_TERM_SHIFT     5
`define CLA_EMPTY_SHIFT    7
`define CLA_FULL_CUR_MIN   16'h0010
`define CLA_WEAR_SHIFT     5
`define CLA_REL_ACTIVE_REMAINING_FULL_CLR  8'h5A
`define CLA_REL_ACTIVE_REMAINING_LOWV_CLR  8'h05
`define CLA_DIV_BITS       5'h17

`endif

// File: cla_pkg.sv
package cla_pkg;

  typedef enum logic [1:0] {
    CLA_IDLE = 2'b00,
    CLA_DIV  = 2'b01,
    CLA_LOAD = 2'b11
  } cla_fsm_t;

  typedef struct packed {
    cla_fsm_t    fsm;
    logic [7:0]  term_cur;
    logic [7:0]  empty_volt;
    logic [7:0]  empty_cur;
    logic [7:0]  full_volt;
    logic [15:0] wear;
    logic [7:0]  ratio;
    logic [15:0] prev_cur;
    logic        prev_vhigh;
    logic        have_prev;
    logic        learn;
    logic        full;
    logic        lowv;
    logic        load;
    logic [15:0] load_val;
    logic [7:0]  rdata;
    logic        save;
    logic [7:0]  save_val;
  } cla_core_st_t;

  typedef struct packed {
    logic [21:0] cnt;
    logic        step;
  } cla_ager_st_t;

  typedef struct packed {
    logic [16:0] rem;
    logic [22:0] dvd;
    logic [15:0] dvs;
    logic [22:0] quo;
    logic [4:0]  cnt;
    logic        busy;
    logic        done;
  } cla_div_st_t;

endpackage : cla_pkg

// File: cla_wear_ager.sv
`timescale 1ns/1ps
`include "cla_regs.svh"

module cla_wear_ager (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        dec_vld_i,
  input  wire logic [15:0] dec_amt_i,
  input  wire logic [15:0] rated_i,
  input  wire logic        clear_i,
  output logic             step_o
);

  cla_pkg::cla_ager_st_t st_q;
  cla_pkg::cla_ager_st_t st_d;

  logic [21:0] limit;
  logic [21:0] sum;

  assign limit = {1'b0, rated_i, 5'h00};
  assign sum   = st_q.cnt + {6'h00, dec_amt_i};

  always_comb
  begin
    st_d      = st_q;
    st_d.step = 1'b0;
    if (clear_i)
    begin
      st_d.cnt = 22'h000000;
    end
    else if (dec_vld_i && (rated_i != 16'h0000))
    begin
      // A zero rated charge would age on every step, so it disables aging instead.
      if (sum >= limit)
      begin
        st_d.cnt  = sum - limit;
        st_d.step = 1'b1;
      end
      else
      begin
        st_d.cnt = sum;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign step_o = st_q.step;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  property p_clear_wins;
    clear_i |=> (st_q.cnt == 22'h000000) && !step_o;
  endproperty
  a_clear_wins: assert property (p_clear_wins) else $error("Wear counter survived a learn.");

  property p_step_at_limit;
    !clear_i && dec_vld_i && (rated_i != 16'h0000) && (sum >= limit) |=> step_o;
  endproperty
  a_step_at_limit: assert property (p_step_at_limit) else $error("Wear step missed at limit.");

endmodule : cla_wear_ager

// File: cla_ratio_div.sv
`timescale 1ns/1ps
`include "cla_regs.svh"

module cla_ratio_div (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic [22:0] dividend_i,
  input  wire logic [15:0] divisor_i,
  output logic             done_o,
  output logic [22:0]      quotient_o
);

  cla_pkg::cla_div_st_t st_q;
  cla_pkg::cla_div_st_t st_d;

  logic [16:0] trial;

  assign trial = {st_q.rem[15:0], st_q.dvd[22]};

  // One quotient bit per clock keeps the area small; a relearn is rare.
  always_comb
  begin
    st_d      = st_q;
    st_d.done = 1'b0;
    if (start_i && !st_q.busy)
    begin
      st_d.rem  = 17'h00000;
      st_d.dvd  = dividend_i;
      st_d.dvs  = divisor_i;
      st_d.quo  = 23'h000000;
      st_d.cnt  = `CLA_DIV_BITS;
      st_d.busy = 1'b1;
    end
    else if (st_q.busy)
    begin
      st_d.dvd = {st_q.dvd[21:0], 1'b0};
      if (trial >= {1'b0, st_q.dvs})
      begin
        st_d.rem = trial - {1'b0, st_q.dvs};
        st_d.quo = {st_q.quo[21:0], 1'b1};
      end
      else
      begin
        st_d.rem = trial;
        st_d.quo = {st_q.quo[21:0], 1'b0};
      end
      st_d.cnt = st_q.cnt - 5'h01;
      if (st_q.cnt == 5'h01)
      begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign done_o     = st_q.done;
  assign quotient_o = st_q.quo;

endmodule : cla_ratio_div

// File: cla_gauge_core.sv
`timescale 1ns/1ps
`include "cla_regs.svh"

module cla_gauge_core (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        prm_wr_i,
  input  wire logic        prm_rd_i,
  input  wire logic [2:0]  prm_addr_i,
  input  wire logic [7:0]  prm_wdata_i,
  output logic [7:0]       prm_rdata_o,
  input  wire logic        ee_recall_i,
  input  wire logic [7:0]  ee_ratio_i,
  output logic             ee_save_o,
  output logic [7:0]       ee_ratio_o,
  input  wire logic        meas_upd_i,
  input  wire logic [9:0]  vin1_i,
  input  wire logic [9:0]  vin2_i,
  input  wire logic [15:0] averaged_current_i,
  input  wire logic [15:0] coulomb_count_i,
  input  wire logic        cc_dec_vld_i,
  input  wire logic [15:0] cc_dec_amt_i,
  input  wire logic        cc_written_i,
  input  wire logic        sleep_i,
  input  wire logic [15:0] full_model_i,
  input  wire logic [15:0] ae_model_i,
  input  wire logic [7:0]  rel_active_remaining_i,
  output logic             cc_load_o,
  output logic [15:0]      cc_load_val_o,
  output logic [7:0]       status_o
);

  cla_pkg::cla_core_st_t st_q;
  cla_pkg::cla_core_st_t st_d;

  logic [10:0] vsum;
  logic [9:0]  vmean;
  logic        vhigh;
  logic        vlow;
  logic        cur_chg_ok;
  logic        prev_chg_ok;
  logic        cur_dis_ok;
  logic        prev_dis_ok;
  logic        full_det;
  logic        ae_det;
  logic        lowv_det;
  logic        age_step;
  logic        div_start;
  logic        div_done;
  logic [22:0] div_quo;
  logic        learn_done;
  logic [7:0]  learned_ratio;
  logic [23:0] full_prod;
  logic [15:0] full_scaled;

  function automatic logic chg_ok(input logic [15:0] cur, input logic [7:0] term);
    logic [15:0] lim;
    lim    = {3'h0, term, 5'h00};
    chg_ok = !cur[15] && (cur > `CLA_FULL_CUR_MIN) && (cur < lim);
  endfunction : chg_ok

  function automatic logic dis_ok(input logic [15:0] cur, input logic [7:0] lim);
    logic [16:0] mag;
    mag    = 17'h00000 - {cur[15], cur};
    dis_ok = cur[15] && (mag > {2'h0, lim, 7'h00});
  endfunction : dis_ok

  function automatic logic [7:0] floor_ratio(input logic [7:0] r);
    floor_ratio = (r < `CLA_RATIO_FLOOR) ? `CLA_RATIO_FLOOR : r;
  endfunction : floor_ratio

  assign vsum        = {1'b0, vin1_i} + {1'b0, vin2_i};
  assign vmean       = vsum[10:1];
  assign vhigh       = vmean > {st_q.full_volt, 2'b00};
  assign vlow        = vmean < {st_q.empty_volt, 2'b00};
  assign cur_chg_ok  = chg_ok(averaged_current_i, st_q.term_cur);
  assign prev_chg_ok = chg_ok(st_q.prev_cur, st_q.term_cur);
  assign cur_dis_ok  = dis_ok(averaged_current_i, st_q.empty_cur);
  assign prev_dis_ok = dis_ok(st_q.prev_cur, st_q.empty_cur);

  // Both detectors look only at the update strobe, the latest reading and the stored one.
  assign full_det = meas_upd_i && st_q.have_prev && vhigh && st_q.prev_vhigh
                    && cur_chg_ok && prev_chg_ok;
  assign ae_det   = meas_upd_i && st_q.have_prev && vlow && cur_dis_ok && prev_dis_ok;
  assign lowv_det = meas_upd_i && vlow;

  // Ratio scaling keeps the full value a fixed-point product with 2^-7 weighting.
  assign full_prod   = {8'h00, full_model_i} * {16'h0000, st_q.ratio};
  assign full_scaled = full_prod[23] ? 16'hFFFF : full_prod[22:7];

  // Start drops with done, or the divider would rerun and hand a stale quotient to the next learn.
  assign div_start     = (st_q.fsm == cla_pkg::CLA_DIV) && !div_done;
  assign learn_done    = (st_q.fsm == cla_pkg::CLA_DIV) && div_done;
  assign learned_ratio = (div_quo > 23'h0000FF) ? 8'hFF : floor_ratio(div_quo[7:0]);

  cla_ratio_div u_div (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .start_i    (div_start),
    .dividend_i ({coulomb_count_i, 7'h00}),
    .divisor_i  (full_model_i),
    .done_o     (div_done),
    .quotient_o (div_quo)
  );

  cla_wear_ager u_ager (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .dec_vld_i (cc_dec_vld_i),
    .dec_amt_i (cc_dec_amt_i),
    .rated_i   (st_q.wear),
    .clear_i   (learn_done),
    .step_o    (age_step)
  );

  always_comb
  begin
    st_d      = st_q;
    st_d.load = 1'b0;
    st_d.save = 1'b0;

    if (meas_upd_i)
    begin
      st_d.prev_cur   = averaged_current_i;
      st_d.prev_vhigh = vhigh;
      st_d.have_prev  = 1'b1;
    end

    if (prm_wr_i)
    begin
      unique case (prm_addr_i)
        `CLA_IDX_TERM_CUR:   st_d.term_cur = prm_wdata_i;
        `CLA_IDX_EMPTY_VOLT: st_d.empty_volt = prm_wdata_i;
        `CLA_IDX_EMPTY_CUR:  st_d.empty_cur = prm_wdata_i;
        `CLA_IDX_WEAR_HI:    st_d.wear[15:8] = prm_wdata_i;
        `CLA_IDX_WEAR_LO:    st_d.wear[7:0] = prm_wdata_i;
        `CLA_IDX_FULL_VOLT:  st_d.full_volt = prm_wdata_i;
        default:             st_d.term_cur = st_q.term_cur;
      endcase
    end

    // Ratio sources, highest first: recall, relearn, host write, aging.
    if (ee_recall_i)
    begin
      st_d.ratio = floor_ratio(ee_ratio_i);
    end
    else if (learn_done)
    begin
      st_d.ratio = learned_ratio;
    end
    else if (prm_wr_i && (prm_addr_i == `CLA_IDX_RATIO))
    begin
      st_d.ratio = floor_ratio(prm_wdata_i);
    end
    else if (age_step && (st_q.ratio > `CLA_RATIO_FLOOR))
    begin
      st_d.ratio = st_q.ratio - 8'h01;
    end

    if ((st_d.ratio != st_q.ratio) && !ee_recall_i)
    begin
      st_d.save     = 1'b1;
      st_d.save_val = st_d.ratio;
    end

    if (prm_rd_i)
    begin
      unique case (prm_addr_i)
        `CLA_IDX_TERM_CUR:   st_d.rdata = st_q.term_cur;
        `CLA_IDX_EMPTY_VOLT: st_d.rdata = st_q.empty_volt;
        `CLA_IDX_EMPTY_CUR:  st_d.rdata = st_q.empty_cur;
        `CLA_IDX_WEAR_HI:    st_d.rdata = st_q.wear[15:8];
        `CLA_IDX_WEAR_LO:    st_d.rdata = st_q.wear[7:0];
        `CLA_IDX_RATIO:      st_d.rdata = st_q.ratio;
        `CLA_IDX_FULL_VOLT:  st_d.rdata = st_q.full_volt;
        `CLA_IDX_STATUS:     st_d.rdata = status_o;
      endcase
    end

    // In every flag a set in the same cycle outranks the clear.
    if (full_det)
    begin
      st_d.full = 1'b1;
    end
    else if (rel_active_remaining_i < `CLA_REL_ACTIVE_REMAINING_FULL_CLR)
    begin
      st_d.full = 1'b0;
    end

    if (ae_det)
    begin
      st_d.learn = 1'b1;
    end
    else if (full_det || (meas_upd_i && averaged_current_i[15]) || cc_written_i || sleep_i
             || (coulomb_count_i == 16'h0000))
    begin
      st_d.learn = 1'b0;
    end

    if (lowv_det)
    begin
      st_d.lowv = 1'b1;
    end
    else if (rel_active_remaining_i > `CLA_REL_ACTIVE_REMAINING_LOWV_CLR)
    begin
      st_d.lowv = 1'b0;
    end

    unique case (st_q.fsm)
      cla_pkg::CLA_IDLE:
      begin
        if (full_det && st_q.learn)
        begin
          st_d.fsm = cla_pkg::CLA_DIV;
        end
        else if (full_det)
        begin
          st_d.load     = 1'b1;
          st_d.load_val = full_scaled;
        end
        else if (ae_det || (lowv_det && st_q.learn))
        begin
          st_d.load     = 1'b1;
          st_d.load_val = ae_model_i;
        end
        else if (lowv_det && (coulomb_count_i > ae_model_i))
        begin
          st_d.load     = 1'b1;
          st_d.load_val = ae_model_i;
        end
      end
      cla_pkg::CLA_DIV:
      begin
        if (div_done)
        begin
          st_d.fsm = cla_pkg::CLA_LOAD;
        end
      end
      cla_pkg::CLA_LOAD:
      begin
        // The full value is scaled by the ratio stored one edge earlier, the relearned one.
        st_d.load     = 1'b1;
        st_d.load_val = full_scaled;
        st_d.fsm      = cla_pkg::CLA_IDLE;
      end
      default:
      begin
        st_d.fsm = cla_pkg::CLA_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      st_q       <= '0;
      st_q.ratio <= `CLA_RST_RATIO;
      st_q.wear  <= `CLA_RST_WEAR;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign prm_rdata_o   = st_q.rdata;
  assign ee_save_o     = st_q.save;
  assign ee_ratio_o    = st_q.save_val;
  assign cc_load_o     = st_q.load;
  assign cc_load_val_o = st_q.load_val;
  assign status_o      = {st_q.full, st_q.lowv, 1'b0, st_q.learn, 4'h0};

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  property p_ratio_floor;
    st_q.ratio >= 8'h40;
  endproperty
  a_ratio_floor: assert property (p_ratio_floor) else $error("Ratio fell under floor.");

  property p_full_flag;
    full_det |=> status_o[7];
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("Full flag not set.");

  property p_learn_arm;
    ae_det |=> status_o[4];
  endproperty
  a_learn_arm: assert property (p_learn_arm) else $error("Learn not armed.");

  property p_lowv_flag;
    lowv_det |=> status_o[6];
  endproperty
  a_lowv_flag: assert property (p_lowv_flag) else $error("Low-voltage flag not set.");

  sequence s_learn_full;
    full_det && st_q.learn && (st_q.fsm == cla_pkg::CLA_IDLE);
  endsequence

  sequence s_relearn_load;
    ##[17:21] (cc_load_o && (st_q.fsm == cla_pkg::CLA_IDLE) && (cc_load_val_o == full_scaled));
  endsequence

  property p_learn_full;
    s_learn_full |=> !status_o[4] && status_o[7];
  endproperty
  a_learn_full: assert property (p_learn_full) else $error("Learn completion flags wrong.");

  property p_relearn_order;
    s_learn_full |-> !cc_load_o ##1 (!cc_load_o)[*8] ##0 s_relearn_load;
  endproperty
  a_relearn_order: assert property (p_relearn_order) else $error("Load not after relearn.");

  property p_ae_load;
    ae_det && !full_det && (st_q.fsm == cla_pkg::CLA_IDLE)
      |=> cc_load_o && (cc_load_val_o == $past(ae_model_i));
  endproperty
  a_ae_load: assert property (p_ae_load) else $error("Empty load missing.");

  property p_no_raise;
    lowv_det && !ae_det && !full_det && !st_q.learn && (st_q.fsm == cla_pkg::CLA_IDLE)
      && (coulomb_count_i <= ae_model_i) |=> !cc_load_o;
  endproperty
  a_no_raise: assert property (p_no_raise) else $error("Count raised to empty value.");

  property p_full_clear;
    !full_det && (rel_active_remaining_i < 8'h5A) |=> !status_o[7];
  endproperty
  a_full_clear: assert property (p_full_clear) else $error("Full flag kept below 90%.");

  property p_save;
    (st_q.ratio != $past(st_q.ratio)) && !$past(ee_recall_i) |-> ee_save_o
      && (ee_ratio_o == st_q.ratio);
  endproperty
  a_save: assert property (p_save) else $error("Ratio change not saved.");

endmodule : cla_gauge_core

// File: cla_host_model.sv
`timescale 1ns/1ps

module cla_host_model (
  input  wire logic       mclk_i,
  output logic            prm_wr_o,
  output logic            prm_rd_o,
  output logic [2:0]      prm_addr_o,
  output logic [7:0]      prm_wdata_o,
  input  wire logic [7:0] prm_rdata_i
);
  initial
  begin
    prm_wr_o    = 1'b0;
    prm_rd_o    = 1'b0;
    prm_addr_o  = 3'h0;
    prm_wdata_o = 8'h00;
  end

  // Strobes rise after a falling edge and drop one cycle later, so each byte is one pulse.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    prm_addr_o  = a;
    prm_wdata_o = d;
    prm_wr_o    = 1'b1;
    @(negedge mclk_i);
    prm_wr_o    = 1'b0;
  endtask : wr

  // Read data is taken one and a half cycles after the read edge, where it is settled and held.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    prm_addr_o = a;
    prm_rd_o   = 1'b1;
    @(negedge mclk_i);
    prm_rd_o   = 1'b0;
    @(negedge mclk_i);
    d = prm_rdata_i;
  endtask : rd

  // A new pack starts below full scale so that a larger cell can still learn upward.
  task automatic build_pack();
    wr(3'h5, 8'h7A);
  endtask : build_pack
endmodule : cla_host_model

// File: tb_cla_gauge_core.sv
`timescale 1ns/1ps
`define CLA_CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_cla_gauge_core;
  typedef struct packed {
    logic [7:0]  rel;
    logic [15:0] cc;
    logic [9:0]  v;
    logic [15:0] i;
    logic [7:0]  st;
    logic        ld;
    logic [15:0] val;
  } cla_mrow_t;

  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        prm_wr, prm_rd, ee_recall = 1'b0, ee_save, meas_upd = 1'b0;
  logic        dec_vld = 1'b0, cc_wr = 1'b0, sleep = 1'b0, cc_load;
  logic [2:0]  prm_addr;
  logic [7:0]  prm_wdata, prm_rdata, ee_val, status, ee_ratio = 8'h00, rel = 8'h64;
  logic [9:0]  vin = 10'h300;
  logic [15:0] avg_cur = 16'h0000, cc = 16'h0800, dec_amt = 16'h0000, cc_val;
  logic [15:0] full_mdl = 16'h1000, ae_mdl = 16'h0100, last_val = 16'h0000;
  logic [7:0]  last_save = 8'h00;
  int          miscompares = 0, n_checks = 0, n_loads = 0, n_saves = 0, k, base;
  logic [18:0] wrows [0:7] = '{{3'h0, 8'h10, 8'h10}, {3'h1, 8'h9A, 8'h9A},
    {3'h2, 8'h10, 8'h10}, {3'h3, 8'h00, 8'h00}, {3'h4, 8'h10, 8'h10},
    {3'h6, 8'hD0, 8'hD0}, {3'h5, 8'h30, 8'h40}, {3'h7, 8'hFF, 8'h00}};
  cla_mrow_t   mr [0:10] = '{
    '{8'h64, 16'h0800, 10'h340, 16'h0100, 8'h00, 1'b0, 16'h0000},
    '{8'h64, 16'h0800, 10'h350, 16'h0010, 8'h00, 1'b0, 16'h0000},
    '{8'h64, 16'h0800, 10'h350, 16'h0010, 8'h00, 1'b0, 16'h0000},
    '{8'h64, 16'h0800, 10'h350, 16'h0200, 8'h00, 1'b0, 16'h0000},
    '{8'h64, 16'h0800, 10'h350, 16'h0011, 8'h00, 1'b0, 16'h0000},
    '{8'h64, 16'h0800, 10'h350, 16'h0011, 8'h80, 1'b1, 16'h0F40},
    '{8'h04, 16'h0800, 10'h300, 16'hFF00, 8'h00, 1'b0, 16'h0000},
    '{8'h04, 16'h0080, 10'h260, 16'hFF00, 8'h40, 1'b0, 16'h0000},
    '{8'h04, 16'h0800, 10'h260, 16'hFF00, 8'h40, 1'b1, 16'h0100},
    '{8'h04, 16'h0080, 10'h260, 16'hF000, 8'h40, 1'b0, 16'h0000},
    '{8'h04, 16'h0080, 10'h260, 16'hF000, 8'h50, 1'b1, 16'h0100}};

  always #25 mclk_i = ~mclk_i;

  cla_gauge_core dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .prm_wr_i(prm_wr), .prm_rd_i(prm_rd),
    .prm_addr_i(prm_addr), .prm_wdata_i(prm_wdata), .prm_rdata_o(prm_rdata),
    .ee_recall_i(ee_recall), .ee_ratio_i(ee_ratio), .ee_save_o(ee_save), .ee_ratio_o(ee_val),
    .meas_upd_i(meas_upd), .vin1_i(vin + 10'h002), .vin2_i(vin - 10'h002),
    .averaged_current_i(avg_cur), .coulomb_count_i(cc), .cc_dec_vld_i(dec_vld),
    .cc_dec_amt_i(dec_amt), .cc_written_i(cc_wr), .sleep_i(sleep), .full_model_i(full_mdl),
    .ae_model_i(ae_mdl), .rel_active_remaining_i(rel), .cc_load_o(cc_load),
    .cc_load_val_o(cc_val), .status_o(status));

  cla_host_model host (
    .mclk_i(mclk_i), .prm_wr_o(prm_wr), .prm_rd_o(prm_rd), .prm_addr_o(prm_addr),
    .prm_wdata_o(prm_wdata), .prm_rdata_i(prm_rdata));

  // One-cycle pulses are caught on every rising edge so that no check depends on exact latency.
  always @(posedge mclk_i)
  begin
    if (cc_load === 1'b1)
    begin
      n_loads  <= n_loads + 1;
      last_val <= cc_val;
    end
    if (ee_save === 1'b1)
    begin
      n_saves   <= n_saves + 1;
      last_save <= ee_val;
    end
  end

  task automatic test_done();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    `CLA_CHK(d, e)
  endtask : chk_rd

  task automatic meas(input logic [7:0] r, input logic [15:0] c, input logic [9:0] v,
                      input logic [15:0] i);
    @(negedge mclk_i);
    rel      = r;
    cc       = c;
    vin      = v;
    avg_cur  = i;
    meas_upd = 1'b1;
    @(negedge mclk_i);
    meas_upd = 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask : meas

  task automatic dec(input logic [15:0] a);
    @(negedge mclk_i);
    dec_vld = 1'b1;
    dec_amt = a;
    @(negedge mclk_i);
    dec_vld = 1'b0;
    repeat (3) @(negedge mclk_i);
  endtask : dec

  task automatic pulse(input int s);
    @(negedge mclk_i);
    case (s)
      0: cc_wr = 1'b1;
      1: sleep = 1'b1;
      default: ee_recall = 1'b1;
    endcase
    @(negedge mclk_i);
    cc_wr     = 1'b0;
    sleep     = 1'b0;
    ee_recall = 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask : pulse

  initial
  begin
    repeat (5) @(negedge mclk_i);
    rst_n_i = 1'b1;
    `CLA_CHK({status, cc_load, ee_save}, 10'h000)
    for (k = 0; k < 8; k++) chk_rd(k[2:0], (k == 5) ? 8'h80 : 8'h00);
    $display("test reset done");
    for (k = 0; k < 8; k++)
    begin
      host.wr(wrows[k][18:16], wrows[k][15:8]);
      chk_rd(wrows[k][18:16], wrows[k][7:0]);
    end
    base = n_saves;
    host.build_pack();
    repeat (2) @(negedge mclk_i);
    `CLA_CHK({n_saves - base, last_save}, {32'd1, 8'h7A})
    $display("test registers done");
    for (k = 0; k < 11; k++)
    begin
      base = n_loads;
      meas(mr[k].rel, mr[k].cc, mr[k].v, mr[k].i);
      `CLA_CHK(status, mr[k].st)
      `CLA_CHK(n_loads - base, int'(mr[k].ld))
      if (mr[k].ld) `CLA_CHK(last_val, mr[k].val)
    end
    $display("test detect done");
    // Count write, sleep and zero count are each tried from a freshly armed state.
    for (k = 0; k < 3; k++)
    begin
      meas(8'h04, 16'h0080, 10'h260, 16'hF000);
      `CLA_CHK(status[4], 1'b1)
      if (k == 2)
      begin
        @(negedge mclk_i);
        cc = 16'h0000;
        repeat (3) @(negedge mclk_i);
        cc = 16'h0080;
      end
      else
        pulse(k);
      `CLA_CHK(status[4], 1'b0)
    end
    $display("test learn clear done");
    dec(16'h01F0);
    meas(8'h04, 16'h0E00, 10'h260, 16'hF000);
    meas(8'h64, 16'h0E00, 10'h350, 16'h0011);
    base = n_loads;
    meas(8'h64, 16'h0E00, 10'h350, 16'h0011);
    for (k = 0; k < 100 && n_loads == base; k++) @(negedge mclk_i);
    `CLA_CHK({n_loads - base, last_val}, {32'd1, 16'h0E00})
    if (n_loads == base) test_done();
    `CLA_CHK(status, 8'h80)
    `CLA_CHK(last_save, 8'h70)
    chk_rd(3'h5, 8'h70);
    $display("test learn done");
    dec(16'h0100);
    dec(16'h00FF);
    chk_rd(3'h5, 8'h70);
    dec(16'h0001);
    chk_rd(3'h5, 8'h6F);
    host.wr(3'h5, 8'h40);
    dec(16'h0200);
    chk_rd(3'h5, 8'h40);
    base = n_saves;
    ee_ratio = 8'h20;
    pulse(2);
    chk_rd(3'h5, 8'h40);
    ee_ratio = 8'h66;
    pulse(2);
    chk_rd(3'h5, 8'h66);
    `CLA_CHK(n_saves - base, 0)
    $display("test aging done");
    test_done();
  end
endmodule : tb_cla_gauge_core
